// ===== hw/paged_linear_mmu.sv
/*
 * Paged and linear memory access unit: page select, linear pointer with
 * three data ports and a signed add port over APB, far call and return
 * sequencing toward the core, and window translation for the flash decoder.
 * Assumes the flash decoder acknowledges each byte request eventually.
 */
// Overview of operation
// - Post-increment port read returns byte, then advances
// - Post-increment port write stores byte, then advances
// - Plain byte port read leaves pointer alone
// - Plain byte port write leaves pointer alone
// - Word and byte post-increment ports behave alike
// - Add port adds signed byte to pointer
// - Pointer holds a 22-bit extended address
// - Pointer accesses ignore the current page select
// - Page select picks 16K block, read/write
// - Window accesses combine page into extended address
// - Far call stacks, pushes page, loads, jumps
// - Far call is not interruptible
// - Far return restores page, then return address
// - Far return uninterruptible, from any address
// - Reset sets page select to two
// - Window address is page above core bits 13:0
`timescale 1ns/1ps
`default_nettype none

module paged_linear_mmu
    import mmu_pkg::*;
#(
    parameter int PTR_W = LIN_PTR_W
)(
    // APB slave
    input  wire logic              pclk,
    input  wire logic              presetn,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [7:0]        paddr,
    input  wire logic [31:0]       pwdata,
    output logic      [31:0]       prdata_r,
    output logic                   pready_r,
    output logic                   pslverr_r,
    // Flash decoder, linear data path
    output mem_req_t               mem_req_r,
    input  wire mem_rsp_t          mem_rsp,
    // Core address translation
    input  wire logic [CPU_AW-1:0] cpu_addr,
    output logic      [EXT_AW-1:0] ext_addr_r,
    output logic                   in_window_r,
    // Far call and return from the core
    input  wire far_req_t          far_req,
    output logic      [PAGE_W-1:0] push_page_r,
    output logic                   push_r,
    output logic                   jump_r,
    output logic      [CPU_AW-1:0] jump_addr_r,
    output logic                   irq_hold_r,
    output logic      [PAGE_W-1:0] page_r
);
    // Narrower pointer could not reach every paged location
    if (PTR_W < EXT_AW || PTR_W > LIN_PTR_W) begin : g_bad_ptr_w
        $error("PTR_W out of range");
    end

    apb_state_t        ap_r, ap_nxt;
    far_state_t        fs_r, fs_nxt;
    logic [PTR_W-1:0]  ptr_r, ptr_nxt;
    logic [PAGE_W-1:0] page_nxt;
    logic [31:0]       prdata_nxt;
    logic              pready_nxt, pslverr_nxt;
    mem_req_t          mem_req_nxt;
    logic [PAGE_W-1:0] push_page_nxt;
    logic              push_nxt, jump_nxt, irq_hold_nxt;
    logic [CPU_AW-1:0] jump_addr_nxt;
    logic [PAGE_W-1:0] far_page_r, far_page_nxt;
    logic [CPU_AW-1:0] far_addr_r, far_addr_nxt;
    logic              postinc_r, postinc_nxt;

    logic              setup, access_done, is_data, is_postinc, mapped;
    logic [23:0]       ptr24;

    assign setup       = psel && !penable;
    assign access_done = psel && penable && pready_r;
    assign is_postinc  = (paddr == OFS_WORD) || (paddr == OFS_BYTE);
    assign is_data     = is_postinc || (paddr == OFS_LIN);
    assign mapped      = is_data || (paddr == OFS_PAGE) || (paddr == OFS_PTR2)
                      || (paddr == OFS_PTR1) || (paddr == OFS_PTR0)
                      || (paddr == OFS_ADD);

    // APB, pointer and linear data path
    always_comb begin
        ap_nxt      = ap_r;
        ptr_nxt     = ptr_r;
        prdata_nxt  = prdata_r;
        pready_nxt  = pready_r;
        pslverr_nxt = pslverr_r;
        mem_req_nxt = mem_req_r;
        postinc_nxt = postinc_r;
        ptr24       = 24'(ptr_r);
        case (ap_r)
            AP_IDLE: begin
                if (setup) begin
                    prdata_nxt  = '0;
                    pslverr_nxt = !mapped;
                    postinc_nxt = is_postinc;
                    if (is_data) begin
                        // Pointer used as is; page select plays no part
                        mem_req_nxt.valid = 1'b1;
                        mem_req_nxt.write = pwrite;
                        mem_req_nxt.addr  = LIN_PTR_W'(ptr_r);
                        mem_req_nxt.wdata = pwdata[7:0];
                        ap_nxt            = AP_MEM;
                    end else begin
                        if (paddr == OFS_PAGE) begin
                            prdata_nxt = 32'(page_r);
                        end else if (paddr == OFS_PTR2) begin
                            prdata_nxt = 32'(ptr24[23:16]);
                        end else if (paddr == OFS_PTR1) begin
                            prdata_nxt = 32'(ptr24[15:8]);
                        end else if (paddr == OFS_PTR0) begin
                            prdata_nxt = 32'(ptr24[7:0]);
                        end
                        pready_nxt = 1'b1;
                        ap_nxt     = AP_DONE;
                    end
                end
            end
            AP_MEM: begin
                if (mem_rsp.ack) begin
                    mem_req_nxt.valid = 1'b0;
                    if (!mem_req_r.write) begin
                        prdata_nxt = 32'(mem_rsp.rdata);
                    end
                    // Advance only once the byte is moved; plain port holds
                    if (postinc_r) begin
                        ptr_nxt = ptr_r + PTR_W'(1);
                    end
                    pready_nxt = 1'b1;
                    ap_nxt     = AP_DONE;
                end
            end
            AP_DONE: begin
                if (access_done) begin
                    pready_nxt  = 1'b0;
                    pslverr_nxt = 1'b0;
                    ap_nxt      = AP_IDLE;
                    if (pwrite) begin
                        if (paddr == OFS_PTR2) begin
                            ptr24[23:16] = pwdata[7:0];
                            ptr_nxt      = ptr24[PTR_W-1:0];
                        end else if (paddr == OFS_PTR1) begin
                            ptr24[15:8] = pwdata[7:0];
                            ptr_nxt     = ptr24[PTR_W-1:0];
                        end else if (paddr == OFS_PTR0) begin
                            ptr24[7:0] = pwdata[7:0];
                            ptr_nxt    = ptr24[PTR_W-1:0];
                        end else if (paddr == OFS_ADD) begin
                            ptr_nxt = ptr_r
                                + {{(PTR_W-8){pwdata[7]}}, pwdata[7:0]};
                        end
                    end
                end
            end
            default: begin
                ap_nxt = AP_IDLE;
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ap_r      <= AP_IDLE;
            ptr_r     <= '0;
            prdata_r  <= '0;
            pready_r  <= 1'b0;
            pslverr_r <= 1'b0;
            mem_req_r <= '0;
            postinc_r <= 1'b0;
        end else begin
            ap_r      <= ap_nxt;
            ptr_r     <= ptr_nxt;
            prdata_r  <= prdata_nxt;
            pready_r  <= pready_nxt;
            pslverr_r <= pslverr_nxt;
            mem_req_r <= mem_req_nxt;
            postinc_r <= postinc_nxt;
        end
    end

    // Far call and return sequencing, page select ownership
    always_comb begin
        fs_nxt        = fs_r;
        page_nxt      = page_r;
        push_page_nxt = push_page_r;
        push_nxt      = 1'b0;
        jump_nxt      = 1'b0;
        jump_addr_nxt = jump_addr_r;
        far_page_nxt  = far_page_r;
        far_addr_nxt  = far_addr_r;
        // Direct write is allowed; paged code should use far ops
        if (ap_r == AP_DONE && access_done && pwrite && paddr == OFS_PAGE) begin
            page_nxt = pwdata[PAGE_W-1:0];
        end
        case (fs_r)
            FS_IDLE: begin
                if (far_req.call) begin
                    far_page_nxt = far_req.page;
                    far_addr_nxt = far_req.addr;
                    fs_nxt       = FS_PUSH;
                end else if (far_req.ret) begin
                    far_page_nxt = far_req.page;
                    far_addr_nxt = far_req.addr;
                    fs_nxt       = FS_RPAGE;
                end
            end
            FS_PUSH: begin
                push_page_nxt = page_r;
                push_nxt      = 1'b1;
                fs_nxt        = FS_LOAD;
            end
            FS_LOAD: begin
                // Far op wins over a same-cycle APB page write
                page_nxt = far_page_r;
                fs_nxt   = FS_JUMP;
            end
            FS_JUMP: begin
                jump_nxt      = 1'b1;
                jump_addr_nxt = far_addr_r;
                fs_nxt        = FS_IDLE;
            end
            FS_RPAGE: begin
                page_nxt = far_page_r;
                fs_nxt   = FS_RPC;
            end
            FS_RPC: begin
                jump_nxt      = 1'b1;
                jump_addr_nxt = far_addr_r;
                fs_nxt        = FS_IDLE;
            end
            default: begin
                fs_nxt = FS_IDLE;
            end
        endcase
        // Held from the cycle after the request until jump_r rises, so no interrupt splits it
        irq_hold_nxt = (fs_nxt != FS_IDLE);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fs_r        <= FS_IDLE;
            page_r      <= PAGE_RST;
            push_page_r <= '0;
            push_r      <= 1'b0;
            jump_r      <= 1'b0;
            jump_addr_r <= '0;
            irq_hold_r  <= 1'b0;
            far_page_r  <= '0;
            far_addr_r  <= '0;
        end else begin
            fs_r        <= fs_nxt;
            page_r      <= page_nxt;
            push_page_r <= push_page_nxt;
            push_r      <= push_nxt;
            jump_r      <= jump_nxt;
            jump_addr_r <= jump_addr_nxt;
            irq_hold_r  <= irq_hold_nxt;
            far_page_r  <= far_page_nxt;
            far_addr_r  <= far_addr_nxt;
        end
    end

    page_window_xlate u_xlate (
        .pclk        (pclk),
        .presetn     (presetn),
        .cpu_addr    (cpu_addr),
        .page        (page_r),
        .ext_addr_r  (ext_addr_r),
        .in_window_r (in_window_r)
    );
endmodule // paged_linear_mmu

`default_nettype wire

// ===== common/mmu_pkg.sv
/*
 * Shared constants and carriers for the paged and linear memory access unit.
 * Assumes a 32-bit APB register bus and a byte-wide flash decoder port.
 */
package mmu_pkg;

    localparam int LIN_PTR_W = 22;
    localparam int PAGE_W    = 3;
    localparam int CPU_AW    = 16;
    localparam int WIN_OFS_W = 14;
    localparam int EXT_AW    = PAGE_W + WIN_OFS_W;

    // APB byte offsets
    localparam logic [7:0] OFS_PAGE = 8'h00;
    localparam logic [7:0] OFS_PTR2 = 8'h04;
    localparam logic [7:0] OFS_PTR1 = 8'h08;
    localparam logic [7:0] OFS_PTR0 = 8'h0C;
    localparam logic [7:0] OFS_WORD = 8'h10;
    localparam logic [7:0] OFS_BYTE = 8'h14;
    localparam logic [7:0] OFS_LIN  = 8'h18;
    localparam logic [7:0] OFS_ADD  = 8'h1C;

    localparam logic [PAGE_W-1:0]    PAGE_RST = 3'h2;
    localparam logic [7:0]           DATA_RST = 8'h00;
    localparam logic [CPU_AW-1:0]    WIN_LO   = 16'h8000;
    localparam logic [CPU_AW-1:0]    WIN_HI   = 16'hBFFF;

    typedef struct packed {
        logic                 valid;
        logic                 write;
        logic [LIN_PTR_W-1:0] addr;
        logic [7:0]           wdata;
    } mem_req_t;

    typedef struct packed {
        logic       ack;
        logic [7:0] rdata;
    } mem_rsp_t;

    typedef struct packed {
        logic              call;
        logic              ret;
        logic [PAGE_W-1:0] page;
        logic [CPU_AW-1:0] addr;
    } far_req_t;

    typedef enum logic [1:0] {
        AP_IDLE = 2'b00,
        AP_MEM  = 2'b01,
        AP_DONE = 2'b10
    } apb_state_t;

    typedef enum logic [2:0] {
        FS_IDLE  = 3'b000,
        FS_PUSH  = 3'b001,
        FS_LOAD  = 3'b010,
        FS_JUMP  = 3'b011,
        FS_RPAGE = 3'b100,
        FS_RPC   = 3'b101
    } far_state_t;

endpackage

// ===== hw/page_window_xlate.sv
/*
 * Registered translation of core addresses in the paging window to
 * extended flash addresses. Assumes page select is stable per access.
 */
`timescale 1ns/1ps
`default_nettype none

module page_window_xlate
    import mmu_pkg::*;
(
    // Clock and reset
    input  wire logic              pclk,
    input  wire logic              presetn,
    // Core address and page
    input  wire logic [CPU_AW-1:0] cpu_addr,
    input  wire logic [PAGE_W-1:0] page,
    // Extended address
    output logic      [EXT_AW-1:0] ext_addr_r,
    output logic                   in_window_r
);
    logic [EXT_AW-1:0] ext_addr_nxt;
    logic              in_window_nxt;

    always_comb begin
        in_window_nxt = (cpu_addr >= WIN_LO) && (cpu_addr <= WIN_HI);
        if (in_window_nxt) begin
            ext_addr_nxt = {page, cpu_addr[WIN_OFS_W-1:0]};
        end else begin
            ext_addr_nxt = EXT_AW'(cpu_addr);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ext_addr_r  <= '0;
            in_window_r <= 1'b0;
        end else begin
            ext_addr_r  <= ext_addr_nxt;
            in_window_r <= in_window_nxt;
        end
    end
endmodule // page_window_xlate

`default_nettype wire

// ===== testbench/flash_model.sv
/* Flash decoder model: byte store, ack at once or after 3 waits.
   Assumes the requester holds its request until the ack. */
`timescale 1ns/1ps
`default_nettype none
module flash_model
    import mmu_pkg::*;
(
    // Clock and reset
    input  wire logic     pclk,
    input  wire logic     presetn,
    // Request, answer, pace
    input  wire mem_req_t req,
    output mem_rsp_t      rsp,
    input  wire logic     slow
);
    logic [7:0] mem [int];
    int         wait_cnt;
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rsp <= '0;
            wait_cnt <= 0;
        end else if (req.valid && !rsp.ack && wait_cnt >= (slow ? 3 : 0)) begin
            rsp.ack <= 1'b1;
            rsp.rdata <= mem.exists(req.addr) ? mem[req.addr] : 8'hFF;
            if (req.write)
                mem[req.addr] = req.wdata;
            wait_cnt <= 0;
        end else begin
            // Junk between answers, so stale data never passes as a read
            rsp.ack <= 1'b0;
            rsp.rdata <= ~rsp.rdata;
            wait_cnt <= req.valid ? wait_cnt + 1 : 0;
        end
    end
endmodule // flash_model
`default_nettype wire

// ===== testbench/mmu_monitor.sv
/* Checker for paged_linear_mmu, bound to its ports.
   Assumes one clock domain and the far sequence timing of the core. */
`timescale 1ns/1ps
`default_nettype none
module mmu_monitor
    import mmu_pkg::*;
#(
    parameter int PTR_W = LIN_PTR_W
)(
    // Clock and reset
    input wire logic              pclk,
    input wire logic              presetn,
    // APB
    input wire logic              psel,
    input wire logic              penable,
    input wire logic              pwrite,
    input wire logic [7:0]        paddr,
    input wire logic [31:0]       pwdata,
    input wire logic [31:0]       prdata_r,
    input wire logic              pready_r,
    // Flash and core sides
    input wire mem_req_t          mem_req_r,
    input wire mem_rsp_t          mem_rsp,
    input wire logic [CPU_AW-1:0] cpu_addr,
    input wire logic [EXT_AW-1:0] ext_addr_r,
    input wire far_req_t          far_req,
    input wire logic [PAGE_W-1:0] push_page_r,
    input wire logic              push_r,
    input wire logic              jump_r,
    input wire logic [CPU_AW-1:0] jump_addr_r,
    input wire logic              irq_hold_r,
    input wire logic [PAGE_W-1:0] page_r
);
    default clocking dclk @(posedge pclk); endclocking
    default disable iff (!presetn);
    far_req_t cap;
    logic     far_go;
    // Requests during a running sequence are dropped, so only idle ones count
    assign far_go = (far_req.call || far_req.ret) && !irq_hold_r;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            cap <= '0;
        else if (far_go)
            cap <= far_req;
    end
    property p_reset_page;
        $rose(presetn) |-> page_r == PAGE_RST;
    endproperty
    a_reset_page: assert property (p_reset_page) else $error("page not 2");
    property p_window;
        cpu_addr >= WIN_LO && cpu_addr <= WIN_HI
            |=> ext_addr_r == {$past(page_r), $past(cpu_addr[13:0])};
    endproperty
    a_window: assert property (p_window) else $error("bad ext addr");
    property p_rdata;
        mem_req_r.valid && mem_rsp.ack && !mem_req_r.write
            |=> pready_r && prdata_r == {24'h0, $past(mem_rsp.rdata)};
    endproperty
    a_rdata: assert property (p_rdata) else $error("bad read data");
    property p_wdata;
        mem_req_r.valid && mem_req_r.write |-> mem_req_r.wdata == pwdata[7:0];
    endproperty
    a_wdata: assert property (p_wdata) else $error("bad write data");
    property p_page_wr;
        psel && penable && pready_r && pwrite && paddr == OFS_PAGE && !irq_hold_r
            |=> page_r == $past(pwdata[PAGE_W-1:0]);
    endproperty
    a_page_wr: assert property (p_page_wr) else $error("page write lost");
    property p_call_go;
        far_go && far_req.call |-> ##[1:3] push_r;
    endproperty
    a_call_go: assert property (p_call_go) else $error("no push");
    property p_call_seq;
        push_r |-> irq_hold_r && push_page_r == page_r ##1 irq_hold_r && page_r == cap.page
            ##1 jump_r && !irq_hold_r && jump_addr_r == cap.addr;
    endproperty
    a_call_seq: assert property (p_call_seq) else $error("bad call");
    property p_ret;
        far_go && far_req.ret |-> ##1 irq_hold_r ##1 (irq_hold_r && page_r == cap.page)
            ##1 (jump_r && !irq_hold_r && page_r == cap.page && jump_addr_r == cap.addr);
    endproperty
    a_ret: assert property (p_ret) else $error("bad return");
endmodule // mmu_monitor
bind paged_linear_mmu mmu_monitor #(.PTR_W(PTR_W)) mmu_monitor_inst (.pclk, .presetn,
    .psel, .penable, .pwrite, .paddr, .pwdata, .prdata_r, .pready_r, .mem_req_r,
    .mem_rsp, .cpu_addr, .ext_addr_r, .far_req, .push_page_r, .push_r, .jump_r,
    .jump_addr_r, .irq_hold_r, .page_r);
`default_nettype wire

// ===== testbench/tb.sv
/* Bench for paged_linear_mmu: APB master tasks, flash model, checker.
   Assumes the flash model acknowledges every byte request. */
`timescale 1ns/1ps
`default_nettype none
module tb
    import mmu_pkg::*;
;
    logic              pclk = 1'b0;
    logic              presetn = 1'b0;
    logic              psel = 1'b0;
    logic              penable = 1'b0;
    logic              pwrite = 1'b0;
    logic [7:0]        paddr = 8'h00;
    logic [31:0]       pwdata = 32'h0;
    logic [31:0]       prdata_r;
    logic              pready_r;
    logic              pslverr_r;
    mem_req_t          mem_req_r;
    mem_rsp_t          mem_rsp;
    logic [CPU_AW-1:0] cpu_addr = 16'h0000;
    logic [EXT_AW-1:0] ext_addr_r;
    logic              in_window_r;
    far_req_t          far_req = '0;
    logic [PAGE_W-1:0] page_r;
    logic              slow = 1'b0;
    logic [31:0]       rd;
    logic              err;
    int                error_cnt = 0;
    int                n_compared = 0;
    paged_linear_mmu paged_linear_mmu_inst (.pclk, .presetn, .psel, .penable,
        .pwrite, .paddr, .pwdata, .prdata_r, .pready_r, .pslverr_r, .mem_req_r,
        .mem_rsp, .cpu_addr, .ext_addr_r, .in_window_r, .far_req, .push_page_r(),
        .push_r(), .jump_r(), .jump_addr_r(), .irq_hold_r(), .page_r);
    flash_model flash_model_inst (.pclk, .presetn, .req(mem_req_r), .rsp(mem_rsp),
        .slow);
    always #5 pclk = ~pclk;
    task automatic tally_and_finish();
        $display("mismatches %0d of %0d", error_cnt, n_compared);
        if (error_cnt == 0 && n_compared > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            error_cnt++;
            $display("wrong value at %0t: %h, expected %h", $time, seen, exp);
        end
    endtask
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // Only the watchdog ends a wait that never completes
        do begin
            @(posedge pclk);
        end while (pready_r !== 1'b1);
        rd = prdata_r;
        err = pslverr_r;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(rd, exp);
    endtask
    task automatic set_ptr(input logic [21:0] p);
        apb(1'b1, OFS_PTR2, {26'h0, p[21:16]});
        apb(1'b1, OFS_PTR1, {24'h0, p[15:8]});
        apb(1'b1, OFS_PTR0, {24'h0, p[7:0]});
    endtask
    task automatic ptr_chk(input logic [21:0] p);
        rchk(OFS_PTR2, {26'h0, p[21:16]});
        rchk(OFS_PTR1, {24'h0, p[15:8]});
        rchk(OFS_PTR0, {24'h0, p[7:0]});
    endtask
    task automatic win(input logic [15:0] a, input logic [31:0] exp);
        @(posedge pclk);
        cpu_addr <= a;
        @(posedge pclk);
        @(negedge pclk);
        chk({14'h0, ext_addr_r, in_window_r}, exp);
    endtask
    task automatic far(input logic c, input logic [2:0] pg, input logic [15:0] a);
        @(posedge pclk);
        far_req <= {c, !c, pg, a};
        @(posedge pclk);
        far_req <= '0;
        repeat (6) @(posedge pclk);
    endtask
    initial begin
        #20000;
        error_cnt++;
        tally_and_finish();
    end
    initial begin
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        rchk(OFS_PAGE, 32'h2);
        rchk(8'h20, 32'h0);
        chk(err, 1'b1);
        rchk(OFS_ADD, 32'h0);
        apb(1'b1, OFS_PAGE, 32'h5);
        rchk(OFS_PAGE, 32'h5);
        set_ptr(22'h3FFFFE);
        ptr_chk(22'h3FFFFE);
        apb(1'b1, OFS_LIN, 32'hA5);
        rchk(OFS_LIN, 32'hA5);
        ptr_chk(22'h3FFFFE);
        apb(1'b1, OFS_WORD, 32'h11);
        apb(1'b1, OFS_BYTE, 32'h22);
        ptr_chk(22'h0);
        set_ptr(22'h3FFFFE);
        slow <= 1'b1;
        rchk(OFS_WORD, 32'h11);
        rchk(OFS_BYTE, 32'h22);
        slow <= 1'b0;
        ptr_chk(22'h0);
        apb(1'b1, OFS_ADD, 32'h7F);
        ptr_chk(22'h7F);
        apb(1'b1, OFS_ADD, 32'h80);
        ptr_chk(22'h3FFFFF);
        win(16'h9234, {14'h0, 3'h5, 14'h1234, 1'b1});
        win(16'h4000, {14'h0, 17'h04000, 1'b0});
        far(1'b1, 3'h6, 16'h8100);
        rchk(OFS_PAGE, 32'h6);
        far(1'b0, 3'h5, 16'h1234);
        rchk(OFS_PAGE, 32'h5);
        // Second reset with a non-default page in place
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        rchk(OFS_PAGE, 32'h2);
        tally_and_finish();
    end
endmodule // tb
`default_nettype wire
